// *** core/flyback_protection_sequencer.v ***
// Protection and mode sequencer of a flyback controller.
// Assumes comparator results and digitised levels synchronous to CLK.
// How it works
// - Overload timer starts above 400 mV
// - 180 ms overload stops switching
// - Overpower restart waits three supply cycles
// - Sense current reaching control level ends stroke
// - Blank sense comparison after switch turn-on
// - Sample sense 2 us after gate falls
// - Four consecutive sense exceedances latch protection
// - Four consecutive supply exceedances latch protection
// - Supply drop clears supply counter
// - High power: fixed 65 kHz
// - Peak power raises frequency and current
// - Low power: 25 % peak, lower frequency
// - Compensation off at low power
// - Overtemperature latches off until supply removal
// - Any protection stops switching immediately
// - Latched protection enters clamped power-down
`timescale 1ns/100ps
`default_nettype none
`include "flyback_seq_regs.vh"
module flyback_protection_sequencer #(
  parameter [31:0] OVERLOAD_CYCLES = `OVERLOAD_CYC  // Overpower time-out in cycles
) (
  input  wire        CLK,          // 200 MHz core clock
  input  wire        RESET,        // Synchronous reset, also supply removal
  input  wire [11:0] CTRL_MV,      // Peak control level in mV
  input  wire [15:0] SUPPLY_MV,    // Supply voltage in mV
  input  wire        SENSE_PEAK,   // Sensed current reached control level
  input  wire        SENSE_OVER,   // Current sense above overvoltage threshold
  input  wire        AT_LOCKOUT,   // Supply reached lockout level
  input  wire        AT_STARTUP,   // Supply reached start-up level
  input  wire        OVER_TEMP,    // Junction overtemperature
  input  wire [1:0]  LOAD_MODE,    // Requested load mode
  output reg         GATE,         // Power switch drive
  output reg  [1:0]  PEAK_SCALE,   // 0:25 %, 1:full, 2:raised peak
  output reg         COMP_ENABLE,  // Overpower compensation current on
  output reg         CLAMP,        // Supply clamp in latched power-down
  output reg         RESTARTING,   // Overpower restart in progress
  output reg         LATCHED       // Latched protection active
);
  localparam [1:0] S_RUN     = 2'h0;
  localparam [1:0] S_DISCH   = 2'h1;
  localparam [1:0] S_RECH    = 2'h2;
  localparam [1:0] S_LATCH   = 2'h3;

  reg  [1:0]  state;
  reg  [1:0]  restarts;
  reg  [31:0] overload;
  reg  [31:0] period_cnt;
  reg  [31:0] blank_cnt;
  reg  [31:0] cur_period;
  reg         gate_q;
  reg         opp_fire;
  wire        sample_done;
  wire        sense_trip;
  wire        supply_trip;
  wire        gate_fall;
  wire        cycle_start;
  wire        switching;

  function [31:0] period_of;
    input [1:0] mode;
    begin
      case (mode)
        `MODE_HIGH: period_of = `HIGH_PERIOD;
        `MODE_PEAK: period_of = `PEAK_PERIOD;
        default:    period_of = `LOW_PERIOD;
      endcase
    end
  endfunction

  assign switching   = (state == S_RUN) && !opp_fire && !sense_trip && !supply_trip && !OVER_TEMP;
  assign gate_fall   = gate_q && !GATE;
  assign cycle_start = switching && (period_cnt == 32'h0);

  // Sample timer launched at each gate fall.
  drive_timer u_sample (
    .clk   (CLK),
    .reset (RESET),
    .start (gate_fall),
    .load  (`SAMPLE_CYC),
    .done  (sample_done)
  );

  cycle_counter u_sense_ovp (
    .clk   (CLK),
    .reset (RESET),
    .check (sample_done),
    .over  (SENSE_OVER),
    .trip  (sense_trip)
  );

  cycle_counter u_supply_ovp (
    .clk   (CLK),
    .reset (RESET),
    .check (cycle_start),
    .over  (SUPPLY_MV > `SUPPLY_OVP_MV),
    .trip  (supply_trip)
  );

  // Overload timer counts while the control level stays above threshold.
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      overload <= 32'h0;
      opp_fire <= 1'b0;
    end
    else
    begin
      opp_fire <= 1'b0;
      if (state != S_RUN || CTRL_MV <= `OVERLOAD_MV)
        overload <= 32'h0;
      else if (overload >= OVERLOAD_CYCLES - 32'h1)
      begin
        overload <= 32'h0;
        opp_fire <= 1'b1;
      end
      else
        overload <= overload + 32'h1;
    end
  end

  // Protection state: restart on overpower, latch on OVP and overtemperature.
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      state    <= S_RUN;
      restarts <= 2'h0;
    end
    else
    begin
      case (state)
        S_RUN:
        begin
          if (sense_trip || supply_trip || OVER_TEMP)
            state <= S_LATCH;
          else if (opp_fire)
          begin
            state    <= S_DISCH;
            restarts <= 2'h0;
          end
        end
        S_DISCH:
        begin
          if (OVER_TEMP)
            state <= S_LATCH;
          else if (AT_LOCKOUT)
            state <= S_RECH;
        end
        S_RECH:
        begin
          if (OVER_TEMP)
            state <= S_LATCH;
          else if (AT_STARTUP)
          begin
            if (restarts == `RESTART_TIMES - 2'h1)
              state <= S_RUN;
            else
            begin
              restarts <= restarts + 2'h1;
              state    <= S_DISCH;
            end
          end
        end
        S_LATCH:
          state <= S_LATCH;
        default:
          state <= S_LATCH;
      endcase
    end
  end

  // Switching period, on-time and blanking.
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      period_cnt <= 32'h0;
      blank_cnt  <= 32'h0;
      cur_period <= 32'h0;
      GATE       <= 1'b0;
      gate_q     <= 1'b0;
    end
    else
    begin
      gate_q <= GATE;
      if (!switching)
      begin
        GATE       <= 1'b0;
        period_cnt <= 32'h0;
      end
      else if (cycle_start)
      begin
        GATE       <= 1'b1;
        blank_cnt  <= `BLANK_CYC;
        cur_period <= period_of(LOAD_MODE);
        period_cnt <= period_of(LOAD_MODE) - 32'h1;
      end
      else
      begin
        period_cnt <= period_cnt - 32'h1;
        if (blank_cnt != 32'h0)
          blank_cnt <= blank_cnt - 32'h1;
        else if (SENSE_PEAK)
          GATE <= 1'b0;
        // The period held from stroke start keeps the duty limit right if the mode
        // changes in mid-period; the live mode would wrap the difference.
        if (cur_period - period_cnt >= `MAX_ON)
          GATE <= 1'b0;
      end
    end
  end

  // Status outputs.
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      PEAK_SCALE  <= `MODE_LOW;
      COMP_ENABLE <= 1'b0;
      CLAMP       <= 1'b0;
      RESTARTING  <= 1'b0;
      LATCHED     <= 1'b0;
    end
    else
    begin
      PEAK_SCALE  <= LOAD_MODE;
      COMP_ENABLE <= switching && LOAD_MODE != `MODE_LOW;
      CLAMP       <= state == S_LATCH;
      RESTARTING  <= state == S_DISCH || state == S_RECH;
      LATCHED     <= state == S_LATCH;
    end
  end
endmodule // flyback_protection_sequencer
`default_nettype wire

// *** core/flyback_seq_regs.vh ***
// Constants for the flyback protection sequencer: timing counts and mode codes.
// Assumes a 200 MHz core clock; analog levels arrive as digital words.
`ifndef FLYBACK_SEQ_REGS_VH
`define FLYBACK_SEQ_REGS_VH

`define CLK_MHZ            200
// Overload time-out 180 ms; count = ms * 1000 * MHz.
`define OVERLOAD_MS        180
`define OVERLOAD_CYC       (`OVERLOAD_MS * 1000 * `CLK_MHZ)
// Sample delay after gate falls: 2 us.
`define SAMPLE_US          2
`define SAMPLE_CYC         (`SAMPLE_US * `CLK_MHZ)
// Peak control threshold 400 mV, in mV on a 12-bit word.
`define OVERLOAD_MV        12'h190
// Supply overvoltage threshold 30 V, in mV on a 16-bit word.
`define SUPPLY_OVP_MV      16'h7530
// Fixed 65 kHz: period in cycles = MHz*1e6/65000.
`define HIGH_FREQ_KHZ      65
`define HIGH_PERIOD        (`CLK_MHZ * 1000 / `HIGH_FREQ_KHZ)
`define PEAK_PERIOD        (`HIGH_PERIOD * 3 / 4)
`define LOW_PERIOD         (`HIGH_PERIOD * 4)
`define MAX_ON             (`HIGH_PERIOD * 4 / 5)
`define BLANK_CYC          20
`define CONSEC_LIMIT       3'h4
`define RESTART_TIMES      2'h3
// Mode codes.
`define MODE_LOW           2'h0
`define MODE_HIGH          2'h1
`define MODE_PEAK          2'h2
`endif

// *** core/cycle_counter.v ***
// Saturating consecutive-cycle counter used for both overvoltage checks.
// Assumes one evaluation strobe per switching cycle.
`timescale 1ns/100ps
`default_nettype none
`include "flyback_seq_regs.vh"
module cycle_counter (
  input  wire       clk,    // Core clock
  input  wire       reset,  // Synchronous reset
  input  wire       check,  // One evaluation per switching cycle
  input  wire       over,   // Level above threshold at evaluation
  output reg        trip    // Four in a row seen
);
  reg [2:0] count;
  always @(posedge clk)
  begin
    if (reset)
    begin
      count <= 3'h0;
      trip  <= 1'b0;
    end
    else if (check)
    begin
      if (!over)
        count <= 3'h0;
      else if (count != `CONSEC_LIMIT)
        count <= count + 3'h1;
      if (over && count == `CONSEC_LIMIT - 3'h1)
        trip <= 1'b1;
    end
  end
endmodule // cycle_counter
`default_nettype wire

// *** core/drive_timer.v ***
// Down counter that ends a timed interval; reloads on start.
// Assumes the load value fits in 32 bits.
`timescale 1ns/100ps
`default_nettype none
module drive_timer (
  input  wire        clk,    // Core clock
  input  wire        reset,  // Synchronous reset
  input  wire        start,  // Load and begin counting
  input  wire [31:0] load,   // Cycles to count
  output reg         done    // Pulses once when count expires
);
  reg [31:0] count;
  reg        run;
  always @(posedge clk)
  begin
    if (reset)
    begin
      count <= 32'h0;
      run   <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        count <= load;
        run   <= 1'b1;
      end
      else if (run)
      begin
        if (count <= 32'h1)
        begin
          run  <= 1'b0;
          done <= 1'b1;
        end
        count <= count - 32'h1;
      end
    end
  end
endmodule // drive_timer
`default_nettype wire

// *** sim/fps_props.sv ***
// Assertions on the sequencer outputs.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module fps_props (
  input wire logic       CLK,         // Clock
  input wire logic       RESET,       // Reset
  input wire logic       OVER_TEMP,   // Hot die
  input wire logic [1:0] LOAD_MODE,   // Mode
  input wire logic       GATE,        // Drive
  input wire logic [1:0] PEAK_SCALE,  // Scale
  input wire logic       COMP_ENABLE, // Comp
  input wire logic       CLAMP,       // Clamp
  input wire logic       RESTARTING,  // Restart
  input wire logic       LATCHED      // Latch
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_rise; !GATE ##1 GATE; endsequence
  // A stroke may end within 8 cycles of its start only when a protection has just stopped switching.
  sequence s_cut; s_rise ##[1:8] !GATE; endsequence
  property p_blank; s_cut |-> ##[0:2] (LATCHED || RESTARTING); endproperty
  a_blank: assert property (p_blank) else $error("gate ended early");
  property p_hold; LATCHED |=> LATCHED; endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_stop; LATCHED || RESTARTING |-> !GATE; endproperty
  a_stop: assert property (p_stop) else $error("gate while stopped");
  property p_clamp; CLAMP == LATCHED; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp wrong");
  property p_temp; OVER_TEMP |-> ##[1:4] LATCHED; endproperty
  a_temp: assert property (p_temp) else $error("no thermal latch");
  property p_comp; PEAK_SCALE == 2'h0 |-> !COMP_ENABLE; endproperty
  a_comp: assert property (p_comp) else $error("comp at low load");
  property p_low; LOAD_MODE == 2'h0 |=> PEAK_SCALE == 2'h0; endproperty
  a_low: assert property (p_low) else $error("low scale");
  property p_peak; LOAD_MODE == 2'h2 |=> PEAK_SCALE == 2'h2; endproperty
  a_peak: assert property (p_peak) else $error("peak scale");
endmodule // fps_props
bind flyback_protection_sequencer fps_props chk_u (.CLK, .RESET, .OVER_TEMP, .LOAD_MODE,
  .GATE, .PEAK_SCALE, .COMP_ENABLE, .CLAMP, .RESTARTING, .LATCHED);
`default_nettype wire

// *** sim/switch_model.sv ***
// Power switch, sense comparator and supply capacitor stand-in.
// Assumes the gate and restart flags change on the core clock.
`timescale 1ns/100ps
`default_nettype none
module switch_model (
  input  wire logic        clk,        // Clock
  input  wire logic        gate,       // Drive
  input  wire logic        restarting, // Restart
  input  wire logic [15:0] on_cyc,     // Ramp length
  output logic             sense_peak, // At level
  output logic             at_lockout, // Low supply
  output logic             at_startup  // Recharged
);
  logic [15:0] on_cnt = 16'h0;
  logic [6:0]  sup_cnt = 7'h0;
  always @(posedge clk)
  begin
    on_cnt <= gate ? on_cnt + 16'h1 : 16'h0;
    sup_cnt <= restarting ? sup_cnt + 7'h1 : 7'h0;
  end
  // The comparator only sees current while the switch conducts.
  assign sense_peak = gate && (on_cnt >= on_cyc);
  assign at_lockout = restarting && (sup_cnt == 7'h32);
  assign at_startup = restarting && (sup_cnt == 7'h63);
endmodule // switch_model
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the flyback sequencer.
// Assumes the switch model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] ctrl_mv = 12'h0;
  logic [15:0] supply_mv = 16'h4e20;
  logic        sense_over = 1'b0;
  logic        over_temp = 1'b0;
  logic [1:0]  load_mode = 2'h1;
  logic [15:0] on_cyc = 16'h5;
  wire         sense_peak, at_lockout, at_startup, gate, comp_enable, clamp, restarting, latched;
  wire  [1:0]  peak_scale;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  flyback_protection_sequencer #(.OVERLOAD_CYCLES(32'd1000)) dut_u (.CLK(clk), .RESET(reset),
    .CTRL_MV(ctrl_mv), .SUPPLY_MV(supply_mv), .SENSE_PEAK(sense_peak), .SENSE_OVER(sense_over),
    .AT_LOCKOUT(at_lockout), .AT_STARTUP(at_startup), .OVER_TEMP(over_temp),
    .LOAD_MODE(load_mode), .GATE(gate), .PEAK_SCALE(peak_scale), .COMP_ENABLE(comp_enable),
    .CLAMP(clamp), .RESTARTING(restarting), .LATCHED(latched));
  switch_model model_u (.clk(clk), .gate(gate), .restarting(restarting), .on_cyc(on_cyc),
    .sense_peak(sense_peak), .at_lockout(at_lockout), .at_startup(at_startup));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rst();
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask
  // An early comparator trip inside blanking must not end the stroke.
  task automatic t_mode(input logic [1:0] m, input int per);
    int t0;
    load_mode <= m;
    rst();
    @(posedge gate);
    t0 = cycles;
    @(negedge gate);
    chk("on_time", 16'h1, 16'(cycles - t0 >= 20 && cycles - t0 <= 24));
    @(posedge gate);
    chk("period", 16'(per), 16'(cycles - t0));
    chk("scale", {14'h0, m}, {14'h0, peak_scale});
    chk("comp", {15'h0, m != 2'h0}, {15'h0, comp_enable});
  endtask
  task automatic t_overload();
    int n;
    ctrl_mv <= 12'h191;
    load_mode <= 2'h1;
    rst();
    repeat (600) @(posedge clk);
    ctrl_mv <= 12'h190;
    @(posedge clk);
    ctrl_mv <= 12'h191;
    repeat (900) @(posedge clk);
    chk("early_restart", 16'h0, {15'h0, restarting});
    repeat (200) @(posedge clk);
    chk("restart", 16'h1, {15'h0, restarting});
    chk("gate_off", 16'h0, {15'h0, gate});
    ctrl_mv <= 12'h0;
    n = 0;
    while (restarting === 1'b1)
    begin
      @(posedge clk);
      n += int'(at_startup);
    end
    chk("laps", 16'h3, 16'(n));
  endtask
  // Each bit of pat is the level for one switching cycle, oldest first.
  task automatic t_pat(input logic sup, input logic [5:0] pat, input logic exp);
    load_mode <= 2'h2;
    rst();
    for (int i = 0; i < 6; i++)
    begin
      @(negedge gate);
      if (sup)
        supply_mv <= pat[i] ? 16'h7531 : 16'h4e20;
      else
        sense_over <= pat[i];
    end
    repeat (2400) @(posedge clk);
    chk("latched", {15'h0, exp}, {15'h0, latched});
    chk("clamp", {15'h0, exp}, {15'h0, clamp});
    sense_over <= 1'b0;
    supply_mv <= 16'h4e20;
  endtask
  task automatic t_temp();
    load_mode <= 2'h1;
    rst();
    over_temp <= 1'b1;
    @(posedge clk);
    over_temp <= 1'b0;
    repeat (100) @(posedge clk);
    chk("hot_latch", 16'h1, {15'h0, latched});
    chk("hot_gate", 16'h0, {15'h0, gate});
    rst();
    chk("released", 16'h0, {15'h0, latched});
  endtask
  initial
  begin
    rst();
    t_mode(2'h1, 3076);
    t_mode(2'h2, 2307);
    t_mode(2'h0, 12304);
    t_overload();
    t_pat(1'b0, 6'b111011, 1'b0);
    t_pat(1'b0, 6'b111100, 1'b1);
    t_pat(1'b1, 6'b111011, 1'b0);
    t_pat(1'b1, 6'b111100, 1'b1);
    t_temp();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
